/* design/clock_tick_divider.sv */
// cpu clock enable divider steered by the clock select register
`timescale 1ns/1ps
`default_nettype none
module clock_tick_divider #(
	parameter int SEL_W = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [SEL_W-1:0] sel,
	output logic tick
);
	localparam int CNT_W = (1 << SEL_W) - 1;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] lastCnt;

	initial begin
		if (SEL_W < 1 || SEL_W > 4) $error("clock_tick_divider: SEL_W must be 1 to 4");
	end

	// one pulse every 2**sel system clocks
	always_comb begin
		lastCnt = CNT_W'((1 << sel) - 1);
		tick = (cnt_ff >= lastCnt);
		nxt_cnt = tick ? '0 : CNT_W'(cnt_ff + 1'b1);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) cnt_ff <= '0;
		else cnt_ff <= nxt_cnt;
	end
endmodule
`default_nettype wire

/* design/operand_addressing_defines.svh */
// register offsets, field positions, reset values and address windows of the operand decoder
`ifndef OPERAND_ADDRESSING_DEFINES_SVH
`define OPERAND_ADDRESSING_DEFINES_SVH

// ==========================================
// register byte offsets
`define OFS_PSW 8'h00
`define OFS_CLKSEL 8'h04
`define OFS_OPREQ 8'h08
`define OFS_OPRES 8'h0C
`define OFS_PC 8'h10
`define OFS_FLAGCMD 8'h14
`define OFS_SAVE 8'h18
`define OFS_GPR 8'h20
`define OFS_PAIR 8'h40
`define OFS_PAIR_END 8'h4C

// ==========================================
// status word fields
`define PSW_CY 0
`define PSW_AC 1
`define PSW_Z 2
`define PSW_RBS_LO 3
`define PSW_RBS_HI 4
`define PSW_IE 5
`define PSW_NMI_IN_SERVICE_FLAG 6
`define PSW_RST 7'h00

// ==========================================
// request, result and flag-command fields
`define REQ_FORM_LO 16
`define REQ_FORM_HI 19
`define REQ_WIDE 20
`define RES_DONE 16
`define RES_REJ 17
`define RES_BUSY 18
`define RES_SLOW 19
`define FC_CY_LO 0
`define FC_AC_LO 3
`define FC_Z_LO 6
`define FC_CY_RES 9
`define FC_AC_RES 10
`define FC_Z_RES 11

// ==========================================
// address windows
`define SADDR_LO 16'hFE20
`define SADDR_HI 16'hFF1F
`define SFR_LO 16'hFF00
`define SFR_HI 16'hFFFF
`define SFR_HOLE_LO 16'hFFD0
`define SFR_HOLE_HI 16'hFFDF
`define SFRP_LO 16'hFF00
`define SFRP_HI 16'hFF1F
`define CALL11_BASE 16'h0800
`define TABLE_BASE 16'h0040
`define HSRAM_LO 16'hFB00
`define HSRAM_HI 16'hFEFF
`define CLKSEL_RST 3'h0
`define PC_RST 16'h0000

`endif

/* design/operand_addressing_legend.sv */
// operand decoder with banked registers, status word and flag update, on an AXI4-Lite slave
// Operation
// RQ1: registers X,A,C,B,E,D,L,H are numbers 0 to 7
// RQ2: pairs numbered 0 to 3: word accumulator, BC, DE, HL
// RQ3: short direct byte address only within FE20H to FF1FH
// RQ4: short direct word address same window, even addresses only
// RQ5: word special registers only word-capable ones at even addresses
// RQ6: special register addresses FFD0H to FFDFH are not addressable
// RQ7: absolute address spans 0000H-FFFFH, even for word transfers
// RQ8: eleven-bit call target lies within 0800H to 0FFFH
// RQ9: call table index selects even addresses 0040H to 007FH
// RQ10: word immediate is 16 bits, byte immediate 8 bits
// RQ11: bit position is 3-bit immediate selecting one of eight
// RQ12: branch displacement is signed 8 bits added to program counter
// RQ13: 8-bit accumulator and 16-bit accumulator pair exist
// RQ14: each pair readable as high byte and low byte
// RQ15: flags carry, half carry, zero, bank, interrupt enable, nmi service
// RQ16: each flag kept, cleared, set, from result, or restored; the flag command does this for carry, half carry and zero only
// RQ17: bank operand selects one of four banks 0 to 3
// RQ18: one instruction cycle is one selected cpu clock cycle
// RQ19: access outside high-speed RAM takes an extra cycle
// RQ20: bank select flag chooses bank for register operands
// RQ21: odd addresses on even-only forms are rejected, never split
`timescale 1ns/1ps
`default_nettype none
`include "operand_addressing_defines.svh"
module operand_addressing_legend #(
	parameter int ADDR_W = 8,
	parameter int DIV_W = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);
	initial begin
		if (ADDR_W < 8) $error("operand_addressing_legend: ADDR_W below 8");
		if (DIV_W < 1 || DIV_W > 4) $error("operand_addressing_legend: DIV_W out of 1..4");
	end

	// ==========================================
	// state
	logic awHeld_ff, wHeld_ff, bValid_ff, rValid_ff, bErr_ff, rErr_ff;
	logic [7:0] awAddr_ff;
	logic [31:0] wData_ff, rData_ff;
	logic [3:0] wStrb_ff;
	logic nxt_awHeld, nxt_wHeld, nxt_bValid, nxt_rValid, nxt_bErr, nxt_rErr;
	logic [7:0] nxt_awAddr;
	logic [31:0] nxt_wData, nxt_rData;
	logic [3:0] nxt_wStrb;
	logic [6:0] psw_ff, savedPsw_ff, nxt_psw, nxt_savedPsw;
	logic [DIV_W-1:0] clkSel_ff, nxt_clkSel;
	logic [15:0] pc_ff, nxt_pc, opVal_ff, nxt_opVal, res_ff, nxt_res;
	logic [7:0] gpr_ff [0:31];
	logic [7:0] nxt_gpr [0:31];
	operand_addressing_pkg::form_e opForm_ff, nxt_opForm;
	logic opWide_ff, busy_ff, phase_ff, resOk_ff, resDone_ff, slow_ff, donePulse_ff;
	logic nxt_opWide, nxt_busy, nxt_phase, nxt_resOk, nxt_resDone, nxt_slow, nxt_donePulse;
	logic cpuTick, wrFire, wrOk, opStart;
	logic [7:0] wrAddr;
	logic [31:0] wrVal;
	logic [15:0] decRes;
	logic decOk, decSlow;
	logic [1:0] bank;

	function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// register file address of register r in the active bank
	function automatic logic [4:0] gprIdx(input logic [1:0] b, input logic [2:0] r);
		return {b, r};
	endfunction

	function automatic logic [6:0] flagStep(input logic [6:0] p, input logic [2:0] code,
		input int pos, input logic resBit, input logic savedBit);
		logic [6:0] q;
		q = p;
		unique case (code)
			3'(operand_addressing_pkg::FLAG_CLEAR): q[pos] = 1'b0; // RQ16
			3'(operand_addressing_pkg::FLAG_SET): q[pos] = 1'b1; // RQ16
			3'(operand_addressing_pkg::FLAG_RESULT): q[pos] = resBit; // RQ16
			3'(operand_addressing_pkg::FLAG_RESTORE): q[pos] = savedBit; // RQ16
			default: q[pos] = p[pos]; // keep, also for unused codes
		endcase
		return q;
	endfunction

	// word seen by a read at byte address a
	function automatic logic [32:0] readWord(input logic [7:0] a);
		logic [32:0] v;
		v = {1'b1, 32'h0000_0000};
		if (a == `OFS_PSW) v[6:0] = psw_ff;
		else if (a == `OFS_CLKSEL) v[DIV_W-1:0] = clkSel_ff;
		else if (a == `OFS_OPREQ) v[20:0] = {opWide_ff, 4'(opForm_ff), opVal_ff};
		else if (a == `OFS_OPRES) v[19:0] = {slow_ff, busy_ff, resDone_ff & ~resOk_ff,
			resDone_ff, res_ff};
		else if (a == `OFS_PC) v[15:0] = pc_ff;
		else if (a == `OFS_FLAGCMD || a == `OFS_SAVE) v[6:0] = savedPsw_ff;
		else if (a >= `OFS_GPR && a < `OFS_PAIR && a[1:0] == 2'b00)
			v[7:0] = gpr_ff[gprIdx(bank, a[4:2])]; // RQ20
		else if (a >= `OFS_PAIR && a <= `OFS_PAIR_END && a[1:0] == 2'b00)
			v[15:0] = {gpr_ff[gprIdx(bank, {a[3:2], 1'b1})],
				gpr_ff[gprIdx(bank, {a[3:2], 1'b0})]}; // RQ2 RQ14 RQ13
		else v[32] = 1'b0;
		return v;
	endfunction

	assign bank = psw_ff[`PSW_RBS_HI:`PSW_RBS_LO]; // RQ15 RQ17

	clock_tick_divider #(.SEL_W(DIV_W)) u_div (
		.clk(clk),
		.rst(rst),
		.sel(clkSel_ff),
		.tick(cpuTick)
	);

	// ==========================================
	// axi4-lite channels
	assign awready = !awHeld_ff && !bValid_ff;
	assign wready = !wHeld_ff && !bValid_ff;
	assign arready = !rValid_ff;
	assign bvalid = bValid_ff;
	assign bresp = bErr_ff ? 2'b10 : 2'b00;
	assign rvalid = rValid_ff;
	assign rdata = rData_ff;
	assign rresp = rErr_ff ? 2'b10 : 2'b00;

	// address and data held separately, write done once both are in
	always_comb begin
		logic [31:0] old;
		old = 32'h0000_0000;
		nxt_awHeld = awHeld_ff | (awvalid & awready);
		nxt_wHeld = wHeld_ff | (wvalid & wready);
		nxt_awAddr = (awvalid & awready) ? awaddr[7:0] : awAddr_ff;
		nxt_wData = (wvalid & wready) ? wdata : wData_ff;
		nxt_wStrb = (wvalid & wready) ? wstrb : wStrb_ff;
		wrFire = nxt_awHeld && nxt_wHeld && !bValid_ff;
		wrAddr = nxt_awAddr;
		{wrOk, old} = readWord(wrAddr);
		if (ADDR_W > 8 && awAddr_ff != nxt_awAddr) wrOk = wrOk;
		for (int i = 0; i < 4; i++) begin
			wrVal[i*8 +: 8] = nxt_wStrb[i] ? nxt_wData[i*8 +: 8] : old[i*8 +: 8];
		end
		nxt_bValid = bValid_ff;
		nxt_bErr = bErr_ff;
		if (wrFire) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld = 1'b0;
			nxt_bValid = 1'b1;
			nxt_bErr = !wrOk;
		end else if (bValid_ff && bready) begin
			nxt_bValid = 1'b0;
		end
		nxt_rValid = rValid_ff;
		nxt_rData = rData_ff;
		nxt_rErr = rErr_ff;
		if (arvalid && arready) begin
			nxt_rValid = 1'b1;
			{nxt_rErr, nxt_rData} = readWord(araddr[7:0]);
			nxt_rErr = !nxt_rErr;
		end else if (rValid_ff && rready) begin
			nxt_rValid = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			bValid_ff <= 1'b0;
			rValid_ff <= 1'b0;
			bErr_ff <= 1'b0;
			rErr_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
			rData_ff <= 32'h0000_0000;
		end else begin
			awHeld_ff <= nxt_awHeld;
			wHeld_ff <= nxt_wHeld;
			bValid_ff <= nxt_bValid;
			rValid_ff <= nxt_rValid;
			bErr_ff <= nxt_bErr;
			rErr_ff <= nxt_rErr;
			awAddr_ff <= nxt_awAddr;
			wData_ff <= nxt_wData;
			wStrb_ff <= nxt_wStrb;
			rData_ff <= nxt_rData;
		end
	end

	// ==========================================
	// operand decode of the latched request
	always_comb begin
		logic [15:0] v;
		v = opVal_ff;
		decRes = v;
		decOk = 1'b1;
		decSlow = 1'b0;
		unique case (opForm_ff)
			operand_addressing_pkg::FORM_R:
				decRes = {8'h00, gpr_ff[gprIdx(bank, v[2:0])]}; // RQ1 RQ20
			operand_addressing_pkg::FORM_RP:
				decRes = {gpr_ff[gprIdx(bank, {v[1:0], 1'b1})],
					gpr_ff[gprIdx(bank, {v[1:0], 1'b0})]}; // RQ2 RQ14 RQ20
			operand_addressing_pkg::FORM_SADDR: decOk = inRange(v, `SADDR_LO, `SADDR_HI); // RQ3
			operand_addressing_pkg::FORM_SADDRP:
				decOk = inRange(v, `SADDR_LO, `SADDR_HI) && !v[0]; // RQ4 RQ21
			operand_addressing_pkg::FORM_SFR:
				decOk = inRange(v, `SFR_LO, `SFR_HI) && !inRange(v, `SFR_HOLE_LO, `SFR_HOLE_HI); // RQ6
			operand_addressing_pkg::FORM_SFRP:
				decOk = inRange(v, `SFRP_LO, `SFRP_HI) && !v[0]
					&& !inRange(v, `SFR_HOLE_LO, `SFR_HOLE_HI); // RQ5 RQ6 RQ21
			operand_addressing_pkg::FORM_ABSOLUTE_ADDRESS_OPERAND: decOk = !(opWide_ff && v[0]); // RQ7 RQ21
			operand_addressing_pkg::FORM_ELEVEN_BIT_CALL_TARGET: decRes = `CALL11_BASE | {5'h00, v[10:0]}; // RQ8
			operand_addressing_pkg::FORM_CALL_TABLE_INDEX: decRes = `TABLE_BASE + {10'h000, v[4:0], 1'b0}; // RQ9
			operand_addressing_pkg::FORM_BYTE: decRes = {8'h00, v[7:0]}; // RQ10
			operand_addressing_pkg::FORM_WORD: decRes = v; // RQ10
			operand_addressing_pkg::FORM_BIT: decRes = 16'h0001 << v[2:0]; // RQ11
			operand_addressing_pkg::FORM_DISP: decRes = pc_ff + {{8{v[7]}}, v[7:0]}; // RQ12
			operand_addressing_pkg::FORM_BANK: decRes = {14'h0000, v[1:0]}; // RQ17
			default: decOk = 1'b0; // unused form codes
		endcase
		// data memory forms outside the fast RAM cost one more cpu cycle
		if (decOk && opForm_ff inside {operand_addressing_pkg::FORM_SADDR,
			operand_addressing_pkg::FORM_SADDRP, operand_addressing_pkg::FORM_SFR,
			operand_addressing_pkg::FORM_SFRP, operand_addressing_pkg::FORM_ABSOLUTE_ADDRESS_OPERAND})
			decSlow = !inRange(v, `HSRAM_LO, `HSRAM_HI); // RQ19
	end

	// ==========================================
	// core registers: status word, requests, register file
	always_comb begin
		opStart = wrFire && wrOk && wrAddr == `OFS_OPREQ && wrVal != 32'h0 - 32'h1 && !busy_ff;
		nxt_psw = psw_ff;
		nxt_savedPsw = savedPsw_ff;
		nxt_clkSel = clkSel_ff;
		nxt_pc = pc_ff;
		nxt_gpr = gpr_ff;
		nxt_opVal = opVal_ff;
		nxt_opForm = opForm_ff;
		nxt_opWide = opWide_ff;
		nxt_busy = busy_ff;
		nxt_phase = phase_ff;
		nxt_res = res_ff;
		nxt_resOk = resOk_ff;
		nxt_resDone = resDone_ff;
		nxt_slow = slow_ff;
		nxt_donePulse = 1'b0;
		if (wrFire && wrOk) begin
			if (wrAddr == `OFS_PSW) nxt_psw = wrVal[6:0]; // RQ15
			if (wrAddr == `OFS_CLKSEL) nxt_clkSel = wrVal[DIV_W-1:0]; // RQ18
			if (wrAddr == `OFS_PC) nxt_pc = wrVal[15:0];
			if (wrAddr == `OFS_SAVE) nxt_savedPsw = psw_ff;
			if (wrAddr == `OFS_FLAGCMD) begin
				nxt_psw = flagStep(nxt_psw, wrVal[`FC_CY_LO +: 3], `PSW_CY,
					wrVal[`FC_CY_RES], savedPsw_ff[`PSW_CY]);
				nxt_psw = flagStep(nxt_psw, wrVal[`FC_AC_LO +: 3], `PSW_AC,
					wrVal[`FC_AC_RES], savedPsw_ff[`PSW_AC]);
				nxt_psw = flagStep(nxt_psw, wrVal[`FC_Z_LO +: 3], `PSW_Z,
					wrVal[`FC_Z_RES], savedPsw_ff[`PSW_Z]);
			end
			if (wrAddr >= `OFS_GPR && wrAddr < `OFS_PAIR)
				nxt_gpr[gprIdx(bank, wrAddr[4:2])] = wrVal[7:0]; // RQ20
			if (wrAddr >= `OFS_PAIR && wrAddr <= `OFS_PAIR_END) begin
				nxt_gpr[gprIdx(bank, {wrAddr[3:2], 1'b1})] = wrVal[15:8]; // RQ14
				nxt_gpr[gprIdx(bank, {wrAddr[3:2], 1'b0})] = wrVal[7:0]; // RQ14
			end
		end
		// a request written while busy is dropped, busy shows in the result word
		if (opStart) begin
			nxt_opVal = wrVal[15:0];
			nxt_opForm = operand_addressing_pkg::form_e'(wrVal[`REQ_FORM_HI:`REQ_FORM_LO]);
			nxt_opWide = wrVal[`REQ_WIDE];
			nxt_busy = 1'b1;
			nxt_phase = 1'b0;
			nxt_resDone = 1'b0;
		end else if (busy_ff && cpuTick) begin
			if (decSlow && !phase_ff) begin
				nxt_phase = 1'b1; // RQ19
			end else begin
				nxt_busy = 1'b0; // RQ18
				nxt_res = decOk ? decRes : 16'h0000;
				nxt_resOk = decOk;
				nxt_resDone = 1'b1;
				nxt_slow = decSlow;
				nxt_donePulse = 1'b1;
				if (decOk && opForm_ff == operand_addressing_pkg::FORM_BANK)
					nxt_psw[`PSW_RBS_HI:`PSW_RBS_LO] = opVal_ff[1:0]; // RQ17
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			psw_ff <= `PSW_RST;
			savedPsw_ff <= `PSW_RST;
			clkSel_ff <= DIV_W'(`CLKSEL_RST);
			pc_ff <= `PC_RST;
			for (int i = 0; i < 32; i++) gpr_ff[i] <= 8'h00;
			opVal_ff <= 16'h0000;
			opForm_ff <= operand_addressing_pkg::FORM_R;
			opWide_ff <= 1'b0;
			busy_ff <= 1'b0;
			phase_ff <= 1'b0;
			res_ff <= 16'h0000;
			resOk_ff <= 1'b0;
			resDone_ff <= 1'b0;
			slow_ff <= 1'b0;
			donePulse_ff <= 1'b0;
		end else begin
			psw_ff <= nxt_psw;
			savedPsw_ff <= nxt_savedPsw;
			clkSel_ff <= nxt_clkSel;
			pc_ff <= nxt_pc;
			gpr_ff <= nxt_gpr;
			opVal_ff <= nxt_opVal;
			opForm_ff <= nxt_opForm;
			opWide_ff <= nxt_opWide;
			busy_ff <= nxt_busy;
			phase_ff <= nxt_phase;
			res_ff <= nxt_res;
			resOk_ff <= nxt_resOk;
			resDone_ff <= nxt_resDone;
			slow_ff <= nxt_slow;
			donePulse_ff <= nxt_donePulse;
		end
	end

	// ==========================================
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence doneOk(operand_addressing_pkg::form_e f);
		donePulse_ff && resOk_ff && opForm_ff == f;
	endsequence
	saddr_window_a: assert property (doneOk(operand_addressing_pkg::FORM_SADDR)
		|-> inRange(res_ff, `SADDR_LO, `SADDR_HI)) else $error("saddr out of window"); // RQ3
	saddrp_even_a: assert property (doneOk(operand_addressing_pkg::FORM_SADDRP)
		|-> !res_ff[0] && inRange(res_ff, `SADDR_LO, `SADDR_HI)) else $error("odd saddrp"); // RQ4
	sfr_hole_a: assert property (doneOk(operand_addressing_pkg::FORM_SFR)
		|-> !inRange(res_ff, `SFR_HOLE_LO, `SFR_HOLE_HI)) else $error("sfr hole hit"); // RQ6
	call_range_a: assert property (doneOk(operand_addressing_pkg::FORM_ELEVEN_BIT_CALL_TARGET)
		|-> res_ff[15:11] == 5'h01) else $error("call target out of range"); // RQ8
	table_even_a: assert property (doneOk(operand_addressing_pkg::FORM_CALL_TABLE_INDEX)
		|-> !res_ff[0] && inRange(res_ff, 16'h0040, 16'h007F)) else $error("bad table entry"); // RQ9
	bit_onehot_a: assert property (doneOk(operand_addressing_pkg::FORM_BIT)
		|-> $onehot(res_ff[7:0]) && res_ff[15:8] == 8'h00) else $error("bit mask wrong"); // RQ11
	odd_reject_a: assert property (donePulse_ff && opWide_ff && opVal_ff[0]
		&& opForm_ff == operand_addressing_pkg::FORM_ABSOLUTE_ADDRESS_OPERAND |-> !resOk_ff)
		else $error("odd word address accepted"); // RQ21
	decode_time_a: assert property (opStart |=> busy_ff ##[0:300] donePulse_ff)
		else $error("decode never finished"); // RQ18
	carry_clear_a: assert property (wrFire && wrOk && wrAddr == `OFS_FLAGCMD
		&& wrVal[2:0] == 3'h1 && !busy_ff |=> !psw_ff[`PSW_CY]) else $error("carry not cleared"); // RQ16
endmodule
`default_nettype wire

/* design/operand_addressing_pkg.sv */
// types shared by the operand decoder files
`default_nettype none
package operand_addressing_pkg;
	// operand forms accepted by the decoder
	typedef enum logic [3:0] {
		FORM_R, FORM_RP, FORM_SADDR, FORM_SADDRP, FORM_SFR, FORM_SFRP, FORM_ABSOLUTE_ADDRESS_OPERAND,
		FORM_ELEVEN_BIT_CALL_TARGET, FORM_CALL_TABLE_INDEX, FORM_BYTE, FORM_WORD, FORM_BIT, FORM_DISP, FORM_BANK
	} form_e;
	// the five ways a flag can be touched
	typedef enum logic [2:0] {
		FLAG_KEEP, FLAG_CLEAR, FLAG_SET, FLAG_RESULT, FLAG_RESTORE
	} flagop_e;
endpackage
`default_nettype wire

/* sim/tb.sv */
// self-checking bench for the operand decoder driven over its register bus
`timescale 1ns/1ps
`default_nettype none
`include "operand_addressing_defines.svh"
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awvalid = 1'b0;
	logic awready;
	logic [7:0] awaddr = 8'h00;
	logic wvalid = 1'b0;
	logic wready;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic bvalid;
	logic bready = 1'b0;
	logic [1:0] bresp;
	logic arvalid = 1'b0;
	logic arready;
	logic [7:0] araddr = 8'h00;
	logic rvalid;
	logic rready = 1'b0;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic [31:0] rd;
	logic [1:0] rsp;
	int error_cnt = 0;
	int cmp_count = 0;
	// ==========================================
	// decode cases: request word, result mask, expected masked result
	logic [31:0] dReq [23] = '{32'h0002FE20, 32'h0002FF1F, 32'h0002FE1F, 32'h0002FF20,
		32'h0003FE21, 32'h0003FE22, 32'h0004FFD0, 32'h0004FFDF, 32'h0004FFE0, 32'h0005FF01,
		32'h0005FF1E, 32'h0005FF20, 32'h00161235, 32'h00061235, 32'h0016FFFE, 32'h000E1234,
		32'h000C0080, 32'h000C007F, 32'h000707FF, 32'h0008001F, 32'h000B0007, 32'h000AFFFF,
		32'h000900FF};
	logic [31:0] dMask [23] = '{32'h000B0000, 32'h000B0000, 32'h00030000, 32'h00030000,
		32'h00030000, 32'h00030000, 32'h00030000, 32'h00030000, 32'h00030000, 32'h00030000,
		32'h00030000, 32'h00030000, 32'h00030000, 32'h00030000, 32'h00030000, 32'h0003FFFF,
		32'h0003FFFF, 32'h0003FFFF, 32'h00030000, 32'h00030000, 32'h00030000, 32'h00030000,
		32'h00030000};
	logic [31:0] dExp [23] = '{32'h00010000, 32'h00090000, 32'h00030000, 32'h00030000,
		32'h00030000, 32'h00010000, 32'h00030000, 32'h00030000, 32'h00010000, 32'h00030000,
		32'h00010000, 32'h00030000, 32'h00030000, 32'h00010000, 32'h00010000, 32'h00030000,
		32'h00010F80, 32'h0001107F, 32'h00010000, 32'h00010000, 32'h00010000, 32'h00010000,
		32'h00010000};
	// flag commands and the status word each should leave behind
	logic [31:0] fCmd [4] = '{32'h0000008C, 32'h000004D8, 32'h000001EB, 32'h00000122};
	logic [31:0] fExp [4] = '{32'h00000065, 32'h00000063, 32'h00000062, 32'h00000065};

	// free-running system clock, 25 ns period
	always #12.5 clk = ~clk;

	operand_addressing_legend operand_addressing_legend_inst (
		.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
	);

	// ==========================================
	// comparison and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("CHECK FAILED t=%0t seen=%08h exp=%08h", $time, seen, exp);
			error_cnt++;
		end
	endtask

	task automatic end_sim();
		$display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ==========================================
	// bus cycles: each begins on a fresh edge so no strobe is assigned twice in one step
	// handshakes are judged on settled values mid-cycle, acted on at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		int n;
		logic aTaken;
		logic wTaken;
		logic bGot;
		r = 2'h3;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			aTaken = awvalid && awready;
			wTaken = wvalid && wready;
			bGot = bvalid;
			if (bGot)
				r = bresp;
			@(posedge clk);
			if (aTaken)
				awvalid <= 1'b0;
			if (wTaken)
				wvalid <= 1'b0;
			if (bGot) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic rdRaw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic arTaken;
		logic rGot;
		d = 32'hFFFFFFFF;
		r = 2'h3;
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(negedge clk);
			arTaken = arvalid && arready;
			rGot = rvalid;
			if (rGot) begin
				d = rdata;
				r = rresp;
			end
			@(posedge clk);
			if (arTaken)
				arvalid <= 1'b0;
			if (rGot) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask

	task automatic wrOk(input logic [7:0] a, input logic [31:0] d);
		wr(a, d, 4'hF, rsp);
		check({30'h0, rsp}, 32'h00000000);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		rdRaw(a, rd, rsp);
		check(rd, exp);
		check({30'h0, rsp}, 32'h00000000);
	endtask

	// polls the result word until the decode has finished; bounded so a hang shows up
	task automatic waitDone();
		int n;
		for (n = 0; n < 40; n++) begin
			rdRaw(`OFS_OPRES, rd, rsp);
			if (rd[`RES_DONE] === 1'b1 && rd[`RES_BUSY] === 1'b0)
				break;
		end
	endtask

	// ==========================================
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdChk(`OFS_PSW, 32'h00000000);
		rdChk(`OFS_CLKSEL, 32'h00000000);
		rdChk(`OFS_PC, 32'h00000000);
		rdChk(`OFS_GPR, 32'h00000000);
		rdChk(`OFS_PAIR, 32'h00000000);
		$display("reset test done");
		// byte registers in order, then seen through the pairs
		for (int i = 0; i < 8; i++)
			wrOk(`OFS_GPR + 8'(4 * i), 32'(8'hC0 + 8'(i)));
		for (int k = 0; k < 4; k++)
			rdChk(`OFS_PAIR + 8'(4 * k), {16'h0, 8'hC1 + 8'(2 * k), 8'hC0 + 8'(2 * k)});
		wr(`OFS_PAIR_END, 32'h00007700, 4'h2, rsp); // only the high byte lane is enabled
		rdChk(`OFS_GPR + 8'h1C, 32'h00000077);
		rdChk(`OFS_GPR + 8'h18, 32'h000000C6);
		$display("register test done");
		// banks keep separate register sets
		wrOk(`OFS_PSW, 32'h00000010);
		rdChk(`OFS_GPR, 32'h00000000);
		wrOk(`OFS_GPR, 32'h000000AA);
		wrOk(`OFS_PSW, 32'h00000000);
		rdChk(`OFS_GPR, 32'h000000C0);
		wrOk(`OFS_OPREQ, 32'h000D0002);
		waitDone();
		rdChk(`OFS_PSW, 32'h00000010);
		rdChk(`OFS_GPR, 32'h000000AA);
		wrOk(`OFS_PSW, 32'h00000000);
		$display("bank test done");
		// every flag operation, with enable and nmi bits left alone
		wrOk(`OFS_PSW, 32'h00000065);
		wrOk(`OFS_SAVE, 32'h00000000);
		wrOk(`OFS_PSW, 32'h00000062);
		for (int i = 0; i < 4; i++) begin
			wrOk(`OFS_FLAGCMD, fCmd[i]);
			rdChk(`OFS_PSW, fExp[i]);
		end
		rdChk(`OFS_FLAGCMD, 32'h00000065);
		wrOk(`OFS_PSW, 32'h00000000);
		$display("flag test done");
		// operand windows, even-only forms, displacement sum
		wrOk(`OFS_PC, 32'h00001000);
		rdChk(`OFS_PC, 32'h00001000);
		for (int i = 0; i < 23; i++) begin
			wrOk(`OFS_OPREQ, dReq[i]);
			waitDone();
			check(rd & dMask[i], dExp[i]);
		end
		$display("decode test done");
		// slow clock: decode stays busy and a second request is dropped
		wrOk(`OFS_CLKSEL, 32'h00000003);
		rdChk(`OFS_CLKSEL, 32'h00000003);
		wrOk(`OFS_OPREQ, 32'h0002FF00);
		wrOk(`OFS_OPREQ, 32'h000E0000);
		rdRaw(`OFS_OPRES, rd, rsp);
		check({31'h0, rd[`RES_BUSY]}, 32'h00000001);
		waitDone();
		check(rd & 32'h000B0000, 32'h00090000);
		wrOk(`OFS_CLKSEL, 32'h00000000);
		$display("clock test done");
		// unmapped offset answers with an error
		wr(8'h50, 32'h12345678, 4'hF, rsp);
		check({30'h0, rsp}, 32'h00000002);
		rdRaw(8'h50, rd, rsp);
		check(rd, 32'h00000000);
		check({30'h0, rsp}, 32'h00000002);
		$display("unmapped test done");
		end_sim();
	end

	// watchdog: far beyond the expected run length
	initial begin
		#1000000;
		error_cnt++;
		end_sim();
	end
endmodule
`default_nettype wire
